// ### sfs_top.sv
/*
 Framed-mode sync control for a serial port: APB control and status
 registers, frame sync pulse generation as master and detection as slave,
 aligned to edges of the bit clock seen on the link.
 Assumes the bit clock and the frame sync pin come from outside the pclk
 domain, and that the shift engine uses word_start to begin a word.
*/
`include "sfs_params.svh"

module sfs_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link pins
   input wire logic bit_clk_pin,
   input wire logic frame_sync_pin_i,
   output logic frame_sync_pin_o,
   output logic frame_sync_pin_oe_n,
   // Ordinary pin role when framing is off
   input wire logic ordinary_o,
   input wire logic ordinary_oe_n,
   // Shift engine side
   input wire logic word_req,
   output logic word_start,
   output logic framing_active
);

   // ==========================================================
   // Bus request bundle
   sfs_pkg::sfs_apb_req_s req;
   assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                  paddr: paddr, pwdata: pwdata};

   // ==========================================================
   // Link pins into the pclk domain
   logic [`SFS_SYNC_W-1:0] pins_s;
   sfs_sync #(.W(`SFS_SYNC_W)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_i({frame_sync_pin_i, bit_clk_pin}),
      .sync_o(pins_s)
   );

   logic clk_s;
   logic fs_s;
   assign clk_s = pins_s[0];
   assign fs_s = pins_s[1];

   // ==========================================================
   // Register state
   sfs_pkg::sfs_ctrl_s ctrl_r, ctrl_nxt;
   logic seen_r, seen_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;

   // ==========================================================
   // Link state
   sfs_pkg::sfs_state_e st_r, st_nxt;
   logic clk_d_r, clk_d_nxt;
   logic fs_prev_r, fs_prev_nxt;
   logic pend_r, pend_nxt;
   logic req_pend_r, req_pend_nxt;
   logic start_r, start_nxt;
   logic fso_r, fso_nxt;
   logic fsoe_n_r, fsoe_n_nxt;
   logic act_r, act_nxt;

   // ==========================================================
   // Decoded bus strobes and link conditions
   logic acc;
   logic wr_fire;
   logic hit_ctrl;
   logic hit_stat;
   logic rise;
   logic fs_active;
   logic is_master;
   logic is_slave;
   logic word_ev;

   assign acc = req.psel && req.penable;
   assign wr_fire = acc && pready_r && req.pwrite;
   assign hit_ctrl = (req.paddr == `SFS_OFS_CTRL);
   assign hit_stat = (req.paddr == `SFS_OFS_STAT);
   // Rising bit clock edge found in the synchronised sample
   assign rise = clk_s && !clk_d_r;
   // Pin level mapped through the chosen polarity
   assign fs_active = (fs_s == ctrl_r.sync_polarity_select);
   assign is_master = ctrl_r.framing_enable && !ctrl_r.sync_direction_select;
   assign is_slave = ctrl_r.framing_enable && ctrl_r.sync_direction_select;
   assign word_ev = start_nxt;

   // ==========================================================
   // APB answer: one wait state, then pready with data
   always_comb begin
      pready_nxt = acc && !pready_r;
      pslverr_nxt = 1'b0;
      prdata_nxt = 32'h0000_0000;
      if (acc && !pready_r) begin
         pslverr_nxt = !(hit_ctrl || hit_stat);
         if (!req.pwrite && hit_ctrl) begin
            // Unimplemented positions stay zero
            prdata_nxt[`SFS_BIT_FRAMING_EN] = ctrl_r.framing_enable;
            prdata_nxt[`SFS_BIT_DIR] = ctrl_r.sync_direction_select;
            prdata_nxt[`SFS_BIT_POL] = ctrl_r.sync_polarity_select;
            prdata_nxt[`SFS_BIT_EDGE] = ctrl_r.sync_edge_select;
         end else if (!req.pwrite && hit_stat) begin
            prdata_nxt[`SFS_BIT_SEEN] = seen_r;
            prdata_nxt[`SFS_BIT_BUSY] = (st_r != sfs_pkg::SFS_IDLE) || pend_r;
            prdata_nxt[`SFS_CNT_HI:`SFS_CNT_LO] = cnt_r;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // ==========================================================
   // Control and status registers
   always_comb begin
      ctrl_nxt = ctrl_r;
      seen_nxt = seen_r;
      cnt_nxt = cnt_r;
      if (wr_fire && hit_ctrl) begin
         // Only the four implemented bits take write data
         ctrl_nxt.framing_enable = req.pwdata[`SFS_BIT_FRAMING_EN];
         ctrl_nxt.sync_direction_select = req.pwdata[`SFS_BIT_DIR];
         ctrl_nxt.sync_polarity_select = req.pwdata[`SFS_BIT_POL];
         ctrl_nxt.sync_edge_select = req.pwdata[`SFS_BIT_EDGE];
      end
      // Write one clears the sticky flag; a new word wins
      if (wr_fire && hit_stat && req.pwdata[`SFS_BIT_SEEN]) begin
         seen_nxt = 1'b0;
      end
      if (word_ev) begin
         seen_nxt = 1'b1;
         cnt_nxt = 8'(cnt_r + 8'h01);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= '{`SFS_CTRL_RST, `SFS_CTRL_RST, `SFS_CTRL_RST, `SFS_CTRL_RST};
         seen_r <= 1'b0;
         cnt_r <= `SFS_CNT_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
         seen_r <= seen_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ==========================================================
   // Frame sync sequencing on bit clock rising edges
   always_comb begin
      st_nxt = st_r;
      clk_d_nxt = clk_s;
      fs_prev_nxt = fs_prev_r;
      pend_nxt = pend_r;
      req_pend_nxt = req_pend_r || (word_req && is_master);
      start_nxt = 1'b0;
      unique case (st_r)
         sfs_pkg::SFS_IDLE: begin
            if (req_pend_nxt && is_master) begin
               st_nxt = sfs_pkg::SFS_ARM;
               req_pend_nxt = 1'b0;
            end
         end
         sfs_pkg::SFS_ARM: begin
            if (rise) begin
               st_nxt = sfs_pkg::SFS_PULSE;
               // Coinciding pulse marks the first bit now
               start_nxt = ctrl_r.sync_edge_select;
            end
         end
         sfs_pkg::SFS_PULSE: begin
            if (rise) begin
               st_nxt = sfs_pkg::SFS_IDLE;
               // Preceding pulse: first bit is this next edge
               start_nxt = !ctrl_r.sync_edge_select;
            end
         end
      endcase
      // Slave: detect a fresh active pulse at a bit clock edge
      if (rise && is_slave) begin
         fs_prev_nxt = fs_active;
         pend_nxt = 1'b0;
         if (pend_r) begin
            start_nxt = 1'b1;
         end else if (fs_active && !fs_prev_r) begin
            if (ctrl_r.sync_edge_select) begin
               start_nxt = 1'b1;
            end else begin
               pend_nxt = 1'b1;
            end
         end
      end
      // Leaving framed master mode drops any sequence in flight
      if (!is_master) begin
         st_nxt = sfs_pkg::SFS_IDLE;
         req_pend_nxt = 1'b0;
      end
      if (!is_slave) begin
         pend_nxt = 1'b0;
         fs_prev_nxt = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= sfs_pkg::SFS_IDLE;
         clk_d_r <= 1'b0;
         fs_prev_r <= 1'b0;
         pend_r <= 1'b0;
         req_pend_r <= 1'b0;
         start_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         clk_d_r <= clk_d_nxt;
         fs_prev_r <= fs_prev_nxt;
         pend_r <= pend_nxt;
         req_pend_r <= req_pend_nxt;
         start_r <= start_nxt;
      end
   end

   // ==========================================================
   // Pin drive: framed master, framed slave, or ordinary role
   always_comb begin
      act_nxt = ctrl_r.framing_enable;
      if (is_master) begin
         // Pulse level follows the polarity choice
         fso_nxt = (st_nxt == sfs_pkg::SFS_PULSE) ?
                   ctrl_nxt.sync_polarity_select : !ctrl_nxt.sync_polarity_select;
         fsoe_n_nxt = 1'b0;
      end else if (is_slave) begin
         fso_nxt = 1'b0;
         fsoe_n_nxt = 1'b1;
      end else begin
         fso_nxt = ordinary_o;
         fsoe_n_nxt = ordinary_oe_n;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fso_r <= 1'b0;
         fsoe_n_r <= 1'b1;
         act_r <= 1'b0;
      end else begin
         fso_r <= fso_nxt;
         fsoe_n_r <= fsoe_n_nxt;
         act_r <= act_nxt;
      end
   end

   // ==========================================================
   // Outputs, all from flops
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign frame_sync_pin_o = fso_r;
   assign frame_sync_pin_oe_n = fsoe_n_r;
   assign word_start = start_r;
   assign framing_active = act_r;

endmodule

// ### sfs_params.svh
/*
 Constants of the framed serial sync control block: register offsets,
 field positions, reset values and synchroniser width.
 Assumes inclusion by bare name from the block's design files.
*/
// Operation
// - Framing enable turns pin into frame sync
// - Direction bit: set slave input, clear master
// - Polarity bit: set active-high, clear active-low
// - Edge bit: set coincides, clear precedes one
// - Unimplemented control bits read zero, writes ignored
`ifndef SFS_PARAMS_SVH
`define SFS_PARAMS_SVH

// ==========================================================
// Register map (byte addresses)
`define SFS_OFS_CTRL 12'h000
`define SFS_OFS_STAT 12'h004

// ==========================================================
// Control field positions
`define SFS_BIT_FRAMING_EN 15
`define SFS_BIT_DIR 14
`define SFS_BIT_POL 13
`define SFS_BIT_EDGE 1

// ==========================================================
// Status field positions
`define SFS_BIT_SEEN 0
`define SFS_BIT_BUSY 1
`define SFS_CNT_LO 8
`define SFS_CNT_HI 15

// ==========================================================
// Reset values
`define SFS_CTRL_RST 1'b0
`define SFS_CNT_RST 8'h00

// ==========================================================
// Synchroniser width for link pins
`define SFS_SYNC_W 2

`endif

// ### sfs_pkg.sv
/*
 Types of the framed serial sync control block.
 Assumes sfs_params.svh is available to the including files.
*/
package sfs_pkg;

   // ==========================================================
   // Framing controls held by software
   typedef struct packed {
      logic framing_enable;
      logic sync_direction_select;
      logic sync_polarity_select;
      logic sync_edge_select;
   } sfs_ctrl_s;

   // ==========================================================
   // APB request as seen by the slave
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } sfs_apb_req_s;

   // ==========================================================
   // Master-side frame pulse sequencer
   typedef enum logic [1:0] {
      SFS_IDLE = 2'b00,
      SFS_ARM = 2'b01,
      SFS_PULSE = 2'b10
   } sfs_state_e;

endpackage

// ### sfs_sync.sv
/*
 Two-flop synchroniser, one lane per bit, for pins outside the pclk domain.
 Assumes pclk and an active-low asynchronous reset.
*/
module sfs_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Asynchronous in, synchronous out
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   // ==========================================================
   // Per-bit double flop; first stage feeds only the second
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_lane
         logic meta_r;
         logic hold_r;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_r <= 1'b0;
               hold_r <= 1'b0;
            end else begin
               meta_r <= async_i[g];
               hold_r <= meta_r;
            end
         end
         assign sync_o[g] = hold_r;
      end
   endgenerate

endmodule

// ### sfs_link_model.sv
/*
 Far-side framed serial device: makes the bit clock and, in slave tests,
 the frame sync pulse.
 Assumes the device pin drive wins whenever its enable is low.
*/
module sfs_link_model (
   // Control from the bench
   input wire logic run,
   input wire logic send,
   input wire logic pol,
   // Device pin drive
   input wire logic dev_o,
   input wire logic dev_oe_n,
   // Link
   output logic bit_clk,
   output logic fs_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph = 2'h0;
   // ==========================
   // Bit clock, still while run is low; edges stay clear of pclk edges
   initial begin
      bit_clk = 1'b0;
      #13;
      forever begin
         #160;
         if (run) bit_clk = ~bit_clk;
      end
   end
   // Inactive bit, then one active bit period of pulse
   always @(negedge bit_clk) begin
      ph <= (ph == 2'h2) ? 2'h0 : (ph == 2'h1 || send) ? ph + 2'h1 : 2'h0;
   end
   // Far side holds the inactive level outside its pulse
   assign fs_in = !dev_oe_n ? dev_o : (ph == 2'h2) ? pol : !pol;
endmodule

// ### sfs_top_monitor.sv
/*
 Checker on the ports of sfs_top.
 Assumes APB masters hold each request until pready.
*/
module sfs_top_monitor (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // Pin and shift side
   input wire logic frame_sync_pin_o,
   input wire logic frame_sync_pin_oe_n,
   input wire logic ordinary_o,
   input wire logic ordinary_oe_n,
   input wire logic word_start,
   input wire logic framing_active
);
   logic [3:0] sh_r, sh_nxt;
   logic [1:0] st_r, st_nxt;
   logic st, mst, rd0;
   // ==========================
   // Shadow of control and settle count
   always_comb begin
      sh_nxt = sh_r;
      st_nxt = (st_r == 2'h3) ? st_r : st_r + 2'h1;
      if (psel && penable && pready && pwrite && paddr == 12'h000) begin
         sh_nxt = {pwdata[15:13], pwdata[1]};
         st_nxt = 2'h0;
      end
   end
   // Shadow registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_r <= 4'h0;
         st_r <= 2'h3;
      end else begin
         sh_r <= sh_nxt;
         st_r <= st_nxt;
      end
   end
   assign st = st_r == 2'h3;
   assign mst = st && sh_r[3:2] == 2'b10;
   assign rd0 = pready && !pwrite && paddr == 12'h000;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================
   // Properties
   property p_zero; rd0 |-> prdata[31:16] == 16'h0000 && prdata[12:2] == 11'h000 && !prdata[0];
   endproperty
   a_zero: assert property (p_zero) else $error("reserved bits not zero");
   property p_back; rd0 |-> {prdata[15:13], prdata[1]} == sh_r; endproperty
   a_back: assert property (p_back) else $error("control readback wrong");
   property p_rst; $rose(presetn) |-> !framing_active && !word_start; endproperty
   a_rst: assert property (p_rst) else $error("framing on after reset");
   property p_pass; $past(presetn) && !framing_active && !$past(framing_active) |->
      frame_sync_pin_o == $past(ordinary_o) && frame_sync_pin_oe_n == $past(ordinary_oe_n);
   endproperty
   a_pass: assert property (p_pass) else $error("pin not in ordinary role");
   property p_ena; st |-> framing_active == sh_r[3]; endproperty
   a_ena: assert property (p_ena) else $error("framing_active wrong");
   property p_slv; st && sh_r[3:2] == 2'b11 |-> frame_sync_pin_oe_n; endproperty
   a_slv: assert property (p_slv) else $error("slave drives pin");
   property p_mst; mst |-> !frame_sync_pin_oe_n; endproperty
   a_mst: assert property (p_mst) else $error("master not driving");
   property p_lead; mst && word_start |-> frame_sync_pin_o == (sh_r[1] ~^ sh_r[0]); endproperty
   a_lead: assert property (p_lead) else $error("pulse level at word start");
   property p_prec; mst && word_start && !sh_r[0] |-> $past(frame_sync_pin_o) == sh_r[1];
   endproperty
   a_prec: assert property (p_prec) else $error("pulse not one bit before");
   property p_rdy; pready |=> !pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready over one cycle");
endmodule
bind sfs_top sfs_top_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .frame_sync_pin_o, .frame_sync_pin_oe_n, .ordinary_o,
   .ordinary_oe_n, .word_start, .framing_active);

// ### sfs_testbench.sv
/*
 Self-checking bench for sfs_top with the far-side link model.
 Assumes one wait state APB and a 320 ns bit clock.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, pol, edg;
   logic ordinary_o = 0, ordinary_oe_n = 1, word_req = 0, run = 0, send = 0, mpol = 0;
   logic pready, pslverr, bit_clk_pin, frame_sync_pin_i, frame_sync_pin_o;
   logic frame_sync_pin_oe_n, word_start, framing_active;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int n_fail = 0, n_tests = 0, cyc = 0;
   initial forever #20 pclk = ~pclk;
   sfs_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .bit_clk_pin, .frame_sync_pin_i, .frame_sync_pin_o,
      .frame_sync_pin_oe_n, .ordinary_o, .ordinary_oe_n, .word_req, .word_start,
      .framing_active);
   sfs_link_model i_far (.run(run), .send(send), .pol(mpol), .dev_o(frame_sync_pin_o),
      .dev_oe_n(frame_sync_pin_oe_n), .bit_clk(bit_clk_pin), .fs_in(frame_sync_pin_i));
   // ==========================
   // Shared tasks
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // Ends on pready; with no bound of its own, only the bench timeout ends it if pready never comes
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wait_ws();
      int k;
      k = 0;
      while (word_start !== 1'b1 && k < 200) begin
         @(posedge pclk);
         k++;
      end
      chk("word_start", word_start, 1);
   endtask
   task stop_test();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ==========================
   // Scenarios
   task t_regs();
      apb(0, 12'h000, 0);
      chk("ctrl reset", rd, 0);
      apb(1, 12'h000, 32'hffff_ffff);
      apb(0, 12'h000, 0);
      chk("ctrl", rd, 32'h0000_e002);
      apb(0, 12'h010, 0);
      chk("unmapped err", er, 1);
      chk("unmapped data", rd, 0);
      apb(1, 12'h000, 0);
      $display("t_regs done");
   endtask
   task t_pass();
      for (int v = 0; v < 2; v++) begin
         @(posedge pclk);
         ordinary_oe_n <= v[0];
         ordinary_o <= !v[0];
         repeat (3) @(posedge pclk);
         chk("pin ordinary", {frame_sync_pin_oe_n, frame_sync_pin_o}, {v[0], !v[0]});
      end
      $display("t_pass done");
   endtask
   task t_master();
      for (int i = 0; i < 4; i++) begin
         {pol, edg} = i[1:0];
         apb(1, 12'h000, {16'h0, 2'b10, pol, 11'h0, edg, 1'b0});
         run <= 1;
         repeat (4) @(posedge pclk);
         chk("idle level", frame_sync_pin_o, !pol);
         word_req <= 1;
         @(posedge pclk);
         word_req <= 0;
         wait_ws();
         chk("pulse level", frame_sync_pin_o, edg ? pol : !pol);
         chk("master oe_n", frame_sync_pin_oe_n, 0);
         repeat (20) @(posedge pclk);
         run <= 0;
      end
      $display("t_master done");
   endtask
   task t_stat();
      apb(0, 12'h004, 0);
      chk("stat", rd, 32'h0000_0401);
      apb(1, 12'h004, 32'h0000_0001);
      apb(0, 12'h004, 0);
      chk("stat cleared", rd, 32'h0000_0400);
      @(posedge pclk);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      apb(0, 12'h000, 0);
      chk("ctrl mid reset", rd, 0);
      apb(0, 12'h004, 0);
      chk("stat mid reset", rd, 0);
      $display("t_stat done");
   endtask
   task t_slave();
      for (int i = 0; i < 2; i++) begin
         apb(1, 12'h000, {16'h0, 2'b11, i[0], 11'h0, i[0], 1'b0});
         mpol <= i[0];
         run <= 1;
         send <= 1;
         wait_ws();
         send <= 0;
         chk("slave oe_n", frame_sync_pin_oe_n, 1);
         repeat (30) @(posedge pclk);
         run <= 0;
      end
      $display("t_slave done");
   endtask
   // ==========================
   // Timeout and main sequence
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      t_regs();
      t_pass();
      t_master();
      t_stat();
      t_slave();
      stop_test();
   end
endmodule
